// File: bench/pioc_core_model.sv
// Behavioural core fabric and pad buffer facing one I/O cell.
// Assumes the bench changes its commands right after rising clock edges.
`timescale 1ns/100ps

module pioc_core_model (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic rise_bit,
    input wire logic fall_bit,
    input wire logic prim_cmd,
    input wire logic sec_cmd,
    input wire logic tri_cmd,
    input wire logic out_ddr,
    // Toward the cell
    output logic pad_in,
    output logic core_out_primary,
    output logic core_out_secondary,
    output logic core_tristate
);
    logic junk_reg;

    // ==========================================================
    // Pad buffer
    // Moves a quarter period after each edge, well clear of both samplings
    initial pad_in = 1'b0;
    always @(negedge clk) pad_in <= #12.5 rise_bit;
    always @(posedge clk) pad_in <= #12.5 fall_bit;

    // ==========================================================
    // Core fabric
    initial junk_reg = 1'b0;
    always @(posedge clk) junk_reg <= ~junk_reg;
    assign core_out_primary = prim_cmd;
    // Secondary toggles outside double rate, so a stray use shows up
    assign core_out_secondary = out_ddr ? sec_cmd : junk_reg;
    assign core_tristate = tri_cmd;
endmodule

// File: bench/tb.sv
// Self-checking bench for the I/O cell: AHB-Lite config, capture and output paths.
// Assumes pioc_cell with default parameters and pioc_core_model as far side.
`timescale 1ns/100ps
`include "pioc_regs.svh"

module tb;
    logic clk, nrst, ce, lsr, rise_bit, fall_bit, prim_cmd, sec_cmd, tri_cmd, out_ddr;
    logic pad_in, pad_out, pad_tristate, bypass_input, bypass_clock_out;
    logic rise_capture_out, fall_capture_out, core_out_primary, core_out_secondary;
    logic core_tristate, strobe_read_shift, strobe_write_shift, capture_phase_polarity;
    logic [4:0] variable_tap_select;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int error_cnt = 0;
    int checked = 0;

    assign hready = hreadyout;

    pioc_core_model model_u (.clk(clk), .rise_bit(rise_bit), .fall_bit(fall_bit),
        .prim_cmd(prim_cmd), .sec_cmd(sec_cmd), .tri_cmd(tri_cmd), .out_ddr(out_ddr),
        .pad_in(pad_in), .core_out_primary(core_out_primary),
        .core_out_secondary(core_out_secondary), .core_tristate(core_tristate));

    pioc_cell dut_u (.clk(clk), .nrst(nrst), .ce(ce), .lsr(lsr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_tristate(pad_tristate), .bypass_input(bypass_input),
        .bypass_clock_out(bypass_clock_out), .rise_capture_out(rise_capture_out),
        .fall_capture_out(fall_capture_out), .core_out_primary(core_out_primary),
        .core_out_secondary(core_out_secondary), .core_tristate(core_tristate),
        .variable_tap_select(variable_tap_select), .strobe_read_shift(strobe_read_shift),
        .strobe_write_shift(strobe_write_shift),
        .capture_phase_polarity(capture_phase_polarity), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Starts on an edge of its own, so callers may come from mid-cycle
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask

    // Single-rate capture latency of n cycles from pad to fall_capture_out
    task automatic latency(input logic [31:0] cfg, input int n);
        int i;
        ahb(1'b1, `PIOC_CFG_OFS, cfg);
        rise_bit <= 1'b0;
        tick(n + 2);
        rise_bit <= 1'b1;
        for (i = 1; i <= n; i++) begin
            tick(1);
            #1 chk(32'(fall_capture_out), 32'(i == n));
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(2000 * 50);
        error_cnt++;
        report_and_stop();
    end

    // ==========================================================
    // Tests
    initial begin
        {nrst, lsr, rise_bit, fall_bit, prim_cmd, sec_cmd, tri_cmd, out_ddr} = 8'h00;
        {hsel, hwrite, htrans, haddr, hwdata, capture_phase_polarity} = '0;
        {ce, strobe_read_shift, strobe_write_shift} = 3'h7;
        variable_tap_select = 5'h00;
        hsize = 3'h2;
        tick(16);
        nrst <= 1'b1;
        tick(1);
        ahb(1'b0, `PIOC_CFG_OFS, 32'h0);
        chk(rdv, 32'(`PIOC_CFG_RST));
        ahb(1'b1, `PIOC_CFG_OFS, 32'hffff_ffff);
        ahb(1'b0, `PIOC_CFG_OFS, 32'h0);
        chk(rdv, 32'h3f);
        ahb(1'b1, 8'h40, 32'h1);
        ahb(1'b0, 8'h40, 32'h0);
        chk(rdv, 32'h0);
        chk(32'(hresp), 32'h0);
        ahb(1'b0, `PIOC_CFG_OFS, 32'h0);
        chk(rdv, 32'h3f);
        variable_tap_select <= 5'h13;
        ahb(1'b0, `PIOC_STAT_OFS, 32'h0);
        chk(32'(rdv[12:8]), 32'h13);
        // Bypass: pad is 0 in the high phase, 1 in the low phase
        ahb(1'b1, `PIOC_CFG_OFS, 32'h1 << `PIOC_CFG_BYP);
        rise_bit <= 1'b1;
        tick(2);
        #20 chk(32'({bypass_input, bypass_clock_out}), 32'h0);
        #25 chk(32'({bypass_input, bypass_clock_out}), 32'h3);
        latency(32'h0, 1);
        latency(32'h1 << `PIOC_CFG_FDLY, 1 + `PIOC_FIXED_DLY_CYC);
        tick(1);
        variable_tap_select <= 5'h03;
        latency(32'h1 << `PIOC_CFG_DDLY, 5);
        ahb(1'b1, `PIOC_CFG_OFS, 32'h1 << `PIOC_CFG_IN_DDR);
        fall_bit <= 1'b0;
        tick(3);
        #1 chk(32'({rise_capture_out, fall_capture_out}), 32'h2);
        tick(1);
        rise_bit <= 1'b0;
        fall_bit <= 1'b1;
        tick(3);
        #1 chk(32'({rise_capture_out, fall_capture_out}), 32'h1);
        tick(1);
        ce <= 1'b0;
        rise_bit <= 1'b1;
        fall_bit <= 1'b0;
        tri_cmd <= 1'b1;
        tick(3);
        #1 chk(32'({rise_capture_out, fall_capture_out, pad_tristate}), 32'h2);
        tick(1);
        ce <= 1'b1;
        tick(2);
        #1 chk(32'({rise_capture_out, fall_capture_out, pad_tristate}), 32'h5);
        tick(1);
        lsr <= 1'b1;
        tick(1);
        #1 chk(32'({rise_capture_out, fall_capture_out, pad_tristate}), 32'h0);
        tick(1);
        lsr <= 1'b0;
        prim_cmd <= 1'b1;
        tick(2);
        #1 chk(32'(pad_out), 32'h1);
        #30 chk(32'(pad_out), 32'h1);
        ahb(1'b1, `PIOC_CFG_OFS, 32'h1 << `PIOC_CFG_OUT_DDR);
        out_ddr <= 1'b1;
        tick(2);
        #10 chk(32'(pad_out), 32'h1);
        #25 chk(32'(pad_out), 32'h0);
        ahb(1'b1, `PIOC_CFG_OFS, 32'h1 << `PIOC_CFG_STRB | 32'h1 << `PIOC_CFG_IN_DDR);
        capture_phase_polarity <= 1'b1;
        tick(3);
        #1 chk(32'({rise_capture_out, fall_capture_out}), 32'h1);
        tick(1);
        strobe_read_shift <= 1'b0;
        rise_bit <= 1'b0;
        fall_bit <= 1'b1;
        tick(3);
        #1 chk(32'({rise_capture_out, fall_capture_out}), 32'h1);
        // Mid-run reset: registers clear and config returns to its reset value
        tick(1);
        nrst <= 1'b0;
        tick(2);
        #1 chk(32'({rise_capture_out, fall_capture_out, pad_tristate, hreadyout}), 32'h0);
        tick(1);
        nrst <= 1'b1;
        tick(1);
        ahb(1'b0, `PIOC_CFG_OFS, 32'h0);
        chk(rdv, 32'(`PIOC_CFG_RST));
        report_and_stop();
    end
endmodule

// File: verilog/pioc_cell.sv
// Register logic of one programmable I/O cell with an AHB-Lite config port.
// Assumes pad and core signals are synchronous to clk; one slave on the bus.
`timescale 1ns/100ps
`include "pioc_regs.svh"

module pioc_cell #(
    parameter bit BOTTOM_EDGE = 1'b1,
    parameter bit RIGHT_EDGE = 1'b1,
    parameter int TAP_W = 5
) (
    // Clock and resets
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic lsr,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_tristate,
    // Core side
    output logic bypass_input,
    output logic bypass_clock_out,
    output logic rise_capture_out,
    output logic fall_capture_out,
    input wire logic core_out_primary,
    input wire logic core_out_secondary,
    input wire logic core_tristate,
    input wire logic [TAP_W-1:0] variable_tap_select,
    // Memory strobes
    input wire logic strobe_read_shift,
    input wire logic strobe_write_shift,
    input wire logic capture_phase_polarity,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    localparam int DEPTH = 1 << TAP_W;

    // ==========================================================
    // Functions
    function automatic pioc_pkg::pioc_in_mode_t in_mode_of(
        input logic [`PIOC_CFG_W-1:0] c
    );
        if (c[`PIOC_CFG_BYP]) begin
            return pioc_pkg::PIOC_IN_BYP;
        end else if (c[`PIOC_CFG_IN_DDR]) begin
            return pioc_pkg::PIOC_IN_DDR;
        end
        return pioc_pkg::PIOC_IN_SDR;
    endfunction

    function automatic logic is_cfg(input logic [7:0] a);
        return a == `PIOC_CFG_OFS;
    endfunction

    // ==========================================================
    // Signals
    logic [`PIOC_CFG_W-1:0] cfg_reg;
    logic [`PIOC_CFG_W-1:0] cfg_view;
    logic [DEPTH-1:0] dly_line_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_val;
    logic hreadyout_reg;
    logic rise_out_reg;
    logic fall_out_reg;
    logic rise_next;
    logic fall_next;
    logic fall_neg_reg;
    logic out_p_reg;
    logic out_s_reg;
    logic tri_reg;
    logic cap_src;
    logic strobe_mode;
    logic swap;
    logic cap_en;
    logic out_en;
    logic ahb_go;
    pioc_pkg::pioc_in_mode_t in_mode;

    // ==========================================================
    // Bus slave
    assign ahb_go = hsel && htrans[1] && hready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (ahb_go) begin
            wr_pend_reg <= hwrite;
            wr_addr_reg <= haddr[7:0];
        end else begin
            wr_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= `PIOC_CFG_RST;
        end else if (wr_pend_reg && is_cfg(wr_addr_reg)) begin
            cfg_reg <= hwdata[`PIOC_CFG_W-1:0];
        end
    end

    // Forward a write still in its data phase so a back-to-back read is fresh
    always_comb begin
        cfg_view = cfg_reg;
        if (wr_pend_reg && is_cfg(wr_addr_reg)) begin
            cfg_view = hwdata[`PIOC_CFG_W-1:0];
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_cfg(haddr[7:0])) begin
            rd_val[`PIOC_CFG_W-1:0] = cfg_view;
        end else if (haddr[7:0] == `PIOC_STAT_OFS) begin
            rd_val[0] = rise_out_reg;
            rd_val[1] = fall_out_reg;
            rd_val[2] = tri_reg;
            rd_val[3] = out_p_reg;
            rd_val[8 +: TAP_W] = variable_tap_select;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
        end else begin
            hrdata_reg <= (ahb_go && !hwrite) ? rd_val : 32'h0000_0000;
            hreadyout_reg <= 1'b1;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;

    // ==========================================================
    // Input section
    assign in_mode = in_mode_of(cfg_reg);
    assign strobe_mode = RIGHT_EDGE && cfg_reg[`PIOC_CFG_STRB];
    assign swap = strobe_mode && capture_phase_polarity;
    assign cap_en = ce && !lsr && (!strobe_mode || strobe_read_shift)
        && (in_mode != pioc_pkg::PIOC_IN_BYP);

    // Straight through, no register on purpose
    assign bypass_input = pad_in;
    assign bypass_clock_out = pad_in;

    // Delay modelled as a sampled line; resolution is one system clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dly_line_reg <= '0;
        end else begin
            dly_line_reg <= {dly_line_reg[DEPTH-2:0], pad_in};
        end
    end

    always_comb begin
        cap_src = pad_in;
        if (cfg_reg[`PIOC_CFG_FDLY]) begin
            cap_src = dly_line_reg[`PIOC_FIXED_DLY_CYC-1];
        end else if (BOTTOM_EDGE && cfg_reg[`PIOC_CFG_DDLY]) begin
            cap_src = dly_line_reg[variable_tap_select];
        end
    end

    always_ff @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            fall_neg_reg <= 1'b0;
        end else if (lsr) begin
            fall_neg_reg <= 1'b0;
        end else if (cap_en) begin
            fall_neg_reg <= cap_src;
        end
    end

    // Falling sample is retimed to the rising edge so outputs share one edge
    always_comb begin
        rise_next = rise_out_reg;
        fall_next = fall_out_reg;
        unique case (in_mode)
            pioc_pkg::PIOC_IN_SDR: begin
                fall_next = cap_src;
            end
            pioc_pkg::PIOC_IN_DDR: begin
                rise_next = swap ? fall_neg_reg : cap_src;
                fall_next = swap ? cap_src : fall_neg_reg;
            end
            pioc_pkg::PIOC_IN_BYP: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rise_out_reg <= 1'b0;
            fall_out_reg <= 1'b0;
        end else if (lsr) begin
            rise_out_reg <= 1'b0;
            fall_out_reg <= 1'b0;
        end else if (cap_en) begin
            rise_out_reg <= rise_next;
            fall_out_reg <= fall_next;
        end
    end

    assign rise_capture_out = rise_out_reg;
    assign fall_capture_out = fall_out_reg;

    // ==========================================================
    // Output and tri-state sections
    assign out_en = ce && !lsr && (!strobe_mode || strobe_write_shift);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_p_reg <= 1'b0;
            out_s_reg <= 1'b0;
        end else if (lsr) begin
            out_p_reg <= 1'b0;
            out_s_reg <= 1'b0;
        end else if (out_en) begin
            out_p_reg <= core_out_primary;
            out_s_reg <= core_out_secondary;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tri_reg <= 1'b0;
        end else if (lsr) begin
            tri_reg <= 1'b0;
        end else if (ce) begin
            tri_reg <= core_tristate;
        end
    end

    assign pad_tristate = tri_reg;
    // High half primary, low half secondary
    assign pad_out = (cfg_reg[`PIOC_CFG_OUT_DDR] && !clk) ? out_s_reg : out_p_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic no_dly;
    assign no_dly = !cfg_reg[`PIOC_CFG_FDLY] && !cfg_reg[`PIOC_CFG_DDLY];

    // Attempts begun on the release edge would see flops still held in reset
    logic armed_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
        end
    end

    tristate_pass_a: assert property (
        armed_reg && ce && !lsr |=> pad_tristate == $past(core_tristate))
        else $error("tri-state not passed on");

    ce_hold_a: assert property (
        !ce && !lsr |=> $stable(rise_capture_out) && $stable(fall_capture_out))
        else $error("capture changed with ce low");

    lsr_clear_a: assert property (
        lsr |=> !rise_capture_out && !fall_capture_out && !pad_tristate)
        else $error("local reset did not clear");

    bypass_hold_a: assert property (
        in_mode == pioc_pkg::PIOC_IN_BYP && !lsr |=> $stable(fall_capture_out))
        else $error("capture moved in bypass");

    sdr_capture_a: assert property (
        armed_reg && ce && !lsr && !strobe_mode && in_mode == pioc_pkg::PIOC_IN_SDR && no_dly
        |=> fall_capture_out == $past(pad_in))
        else $error("sdr capture wrong");

    fixed_delay_a: assert property (
        ce && !lsr && !strobe_mode && in_mode == pioc_pkg::PIOC_IN_SDR
        && cfg_reg[`PIOC_CFG_FDLY] && $stable(cfg_reg)
        |=> fall_capture_out == $past(pad_in, 3))
        else $error("fixed delay wrong");

    ddr_rise_a: assert property (
        ce && !lsr && !strobe_mode && in_mode == pioc_pkg::PIOC_IN_DDR && no_dly
        |=> rise_capture_out == $past(pad_in))
        else $error("ddr rising capture wrong");

    phase_swap_a: assert property (
        ce && !lsr && swap && strobe_read_shift && no_dly
        && in_mode == pioc_pkg::PIOC_IN_DDR |=> fall_capture_out == $past(pad_in))
        else $error("phase swap wrong");

    out_regs_a: assert property (
        armed_reg && out_en |=> out_p_reg == $past(core_out_primary)
        && out_s_reg == $past(core_out_secondary))
        else $error("output registers wrong");

    cfg_write_a: assert property (
        wr_pend_reg && is_cfg(wr_addr_reg) |=> cfg_reg == $past(hwdata[5:0]))
        else $error("config write lost");

    sdr_out_a: assert property (
        armed_reg && out_en && !cfg_reg[`PIOC_CFG_OUT_DDR] && !wr_pend_reg
        |=> pad_out == $past(core_out_primary))
        else $error("single-rate output used secondary");

    ddr_out_low_a: assert property (
        armed_reg && out_en && cfg_reg[`PIOC_CFG_OUT_DDR] && !wr_pend_reg
        |=> pad_out == $past(core_out_secondary))
        else $error("low half not secondary");

    // Sampled just before the falling edge, while the high half stands
    ddr_out_high_a: assert property (
        @(negedge clk) cfg_reg[`PIOC_CFG_OUT_DDR] |-> pad_out == out_p_reg)
        else $error("high half not primary");

    strobe_hold_a: assert property (
        armed_reg && strobe_mode && !strobe_read_shift && !lsr
        |=> $stable(rise_capture_out) && $stable(fall_capture_out))
        else $error("capture moved without read strobe");

    bypass_cov: cover property (in_mode == pioc_pkg::PIOC_IN_BYP ##1 pad_in);
    ddr_in_cov: cover property (in_mode == pioc_pkg::PIOC_IN_DDR && cap_en);
    ddr_out_cov: cover property (cfg_reg[`PIOC_CFG_OUT_DDR] && out_en);
    swap_cov: cover property (swap && cap_en);

endmodule

// File: verilog/pioc_pkg.sv
// Types shared by the I/O cell.
// Assumes pioc_regs.svh carries all numeric constants.
package pioc_pkg;
    typedef enum logic [2:0] {
        PIOC_IN_SDR = 3'b001,
        PIOC_IN_DDR = 3'b010,
        PIOC_IN_BYP = 3'b100
    } pioc_in_mode_t;
endpackage

// File: verilog/pioc_regs.svh
// Offsets, field positions, reset values and timing counts of the I/O cell.
// Assumes a 20 MHz system clock and AHB-Lite word accesses.
`ifndef PIOC_REGS_SVH
`define PIOC_REGS_SVH

// ==========================================================
// Register map
`define PIOC_CFG_OFS 8'h00
`define PIOC_STAT_OFS 8'h04
`define PIOC_CFG_W 6
`define PIOC_CFG_RST 6'h00
`define PIOC_CFG_BYP 0
`define PIOC_CFG_FDLY 1
`define PIOC_CFG_DDLY 2
`define PIOC_CFG_IN_DDR 3
`define PIOC_CFG_OUT_DDR 4
`define PIOC_CFG_STRB 5

// ==========================================================
// Timing
`define PIOC_CLK_NS 50
`define PIOC_FIXED_DLY_NS 100
`define PIOC_FIXED_DLY_CYC ((`PIOC_FIXED_DLY_NS + `PIOC_CLK_NS - 1) / `PIOC_CLK_NS)

`endif
